// [src/gdfm_fault_manager.sv]
// Gate driver disable, braking and supply fault manager
`timescale 1ns/1ps
module gdfm_fault_manager #(
    parameter bit HW_CFG = 1'b0,
    parameter bit EIGHT_BR = 1'b1
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Register port
    input wire logic [gdfm_pkg::AW-1:0] regAddr,
    input wire logic [gdfm_pkg::DW-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [gdfm_pkg::DW-1:0] regRdData,
    // Host pins
    input wire logic sleepRequestN,
    input wire logic disableOrIrqPinIn,
    output logic disableOrIrqPinOut,
    output logic disableOrIrqPinOeN,
    output logic faultOutN,
    input wire logic brakePin,
    input wire logic brakePinOpen,
    // Analog comparators
    input wire logic brakeSupplyHighCmp,
    input wire logic brakeOverCurrentCmp,
    input wire logic logicSupplyLowCmp,
    input wire logic supplyLowCmp,
    input wire logic supplyHighCmp,
    // Analog controls
    output logic [1:0] supplyHighThresholdSelect,
    output logic brakeMonitorEn,
    output logic monitorsEn,
    output logic chargePumpEn,
    // Gate driver controls
    output logic gatePulldownEn,
    output logic [7:0] lowSideBrake
);
    import gdfm_pkg::*;

    // Pin synchroniser, two flops before use
    logic [PIN_N-1:0] syncA_q;
    logic [PIN_N-1:0] pin_q;
    wire [PIN_N-1:0] pinRaw = {supplyHighCmp, supplyLowCmp,
        logicSupplyLowCmp, brakeSupplyHighCmp, brakePinOpen,
        brakePin, disableOrIrqPinIn, sleepRequestN};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncA_q <= '0;
            pin_q <= '0;
        end else if (clkEn) begin
            syncA_q <= pinRaw;
            pin_q <= syncA_q;
        end
    end

    // Brake overcurrent comparator is analog as well, so it gets two flops
    logic bocA_q;
    logic boc_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bocA_q <= 1'b0;
            boc_q <= 1'b0;
        end else if (clkEn) begin
            bocA_q <= brakeOverCurrentCmp;
            boc_q <= bocA_q;
        end
    end

    // Software registers
    logic [DW-1:0] ctrl_q;
    logic [DW-1:0] cfg_q;
    logic clr_q;
    logic [DW-1:0] rdData_q;

    wire wrCtrl = regWr && (regAddr == ADDR_CTRL);
    wire wrCfg = regWr && (regAddr == ADDR_CFG);

    // Hardware variant has no enable or clear bit
    wire enBit = HW_CFG ? 1'b1 : ctrl_q[CTRL_EN]; // R3
    wire clrEff = HW_CFG ? 1'b1 : clr_q; // R11
    wire pinSel = HW_CFG ? 1'b0 : ctrl_q[CTRL_PINSEL];
    wire uvAuto = HW_CFG || (cfg_q[CFG_UVMODE] == UVM_AUTO); // R17
    wire [1:0] ovMode = HW_CFG ? OVM_OFF
        : cfg_q[CFG_OVMODE +: 2]; // R22 R23
    wire [1:0] ovDgSel = cfg_q[CFG_OVDG +: 2];

    // Control and config writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RST; // R2
            cfg_q <= CFG_RST;
        end else if (clkEn) begin
            if (wrCtrl) begin
                ctrl_q <= regWrData;
            end
            if (wrCfg) begin
                cfg_q <= regWrData;
            end
        end
    end

    // Clear strobe lasts one cycle, then drops itself
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clr_q <= 1'b0;
        end else if (clkEn) begin
            clr_q <= wrCtrl && regWrData[CTRL_CLR]; // R10
        end
    end

    // Inactive state from sleep or low logic supply
    logic inactive_q;
    logic [3:0] dg;
    wire sleepOn = !pin_q[P_SLEEPN];
    wire inactiveD = sleepOn || dg[0]; // R12

    // Deglitch limits: logic low, supply low, supply high, brake OC
    logic [CNT_W-1:0] dgLim [4];
    logic [3:0] dgCond;
    wire [CNT_W-1:0] ovDgCyc = (ovDgSel == 2'h0) ? OV_DG0_CYC
        : (ovDgSel == 2'h1) ? OV_DG1_CYC
        : (ovDgSel == 2'h2) ? OV_DG2_CYC : OV_DG3_CYC; // R18
    assign dgLim[0] = POR_DG_CYC;
    assign dgLim[1] = UV_DG_CYC;
    assign dgLim[2] = ovDgCyc;
    assign dgLim[3] = BOC_DG_CYC;
    // Supply low and supply high monitors stay blind while inactive
    assign dgCond[0] = pin_q[P_LLOW];
    assign dgCond[1] = pin_q[P_UV] && !inactive_q; // R12
    assign dgCond[2] = pin_q[P_OV] && !inactive_q;
    assign dgCond[3] = boc_q; // R8

    // Deglitch counters; condition must hold the full time
    for (genvar i = 0; i < 4; i++) begin : g_dg
        logic [CNT_W-1:0] cnt_q;
        wire done = (cnt_q == dgLim[i]);
        assign dg[i] = done;
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                cnt_q <= '0;
            end else if (clkEn) begin
                if (!dgCond[i]) begin
                    cnt_q <= '0;
                end else if (!done) begin
                    cnt_q <= cnt_q + CNT_W'(1);
                end
            end
        end
    end

    // Supply low: fault and flag next state
    logic uvFault_q;
    logic uvFlag_q;
    wire uvDg = dg[1];
    // Set wins; latched mode waits for clear, auto follows condition
    wire uvFaultD = uvDg
        || (uvFault_q && !uvAuto && !clrEff); // R14 R15 R16
    wire uvFlagD = uvDg || (uvFlag_q && !clrEff); // R16

    // Supply high: mode dependent action
    logic ovFault_q;
    logic ovFlag_q;
    logic warn_q;
    wire ovDg = dg[2];
    wire ovSeen = ovDg && (ovMode != OVM_OFF); // R22
    wire ovActs = ovDg
        && ((ovMode == OVM_LATCH) || (ovMode == OVM_AUTO)); // R18
    wire ovFaultD = ovActs || (ovFault_q && (ovMode == OVM_LATCH)
        && !clrEff && !ovDg) || (ovFault_q && ovDg
        && (ovMode != OVM_WARN) && (ovMode != OVM_OFF)); // R19 R20
    wire ovFlagD = ovSeen || (ovFlag_q && !clrEff); // R20
    wire warnD = (ovSeen && (ovMode == OVM_WARN))
        || (warn_q && !clrEff); // R21

    // Power-on-reset flag, raised again by a logic supply dip
    logic por_q;
    wire porD = dg[0] || (por_q && !clrEff); // R13

    // Fault state registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            uvFault_q <= 1'b0;
            uvFlag_q <= 1'b0;
            ovFault_q <= 1'b0;
            ovFlag_q <= 1'b0;
            warn_q <= 1'b0;
            por_q <= 1'b1;
            inactive_q <= 1'b1;
        end else if (clkEn) begin
            uvFault_q <= uvFaultD;
            uvFlag_q <= uvFlagD;
            ovFault_q <= ovFaultD;
            ovFlag_q <= ovFlagD;
            warn_q <= warnD;
            por_q <= porD;
            inactive_q <= inactiveD;
        end
    end

    // Global fault excludes the warning-only path
    wire faultNow = uvFault_q || ovFault_q; // R24

    // Driver disable sources, any one forces pulldowns
    wire pinDisable = !pinSel && pin_q[P_MULTI]; // R5
    wire pulldownD = pinDisable || !enBit
        || faultNow || inactive_q; // R1 R14 R19

    // Braking: request from pin, or supply monitor when pin is open
    logic brakeOc_q;
    wire brakeOpen = pin_q[P_BOPEN];
    wire brakeReq = pin_q[P_BRAKE]
        || (brakeOpen && pin_q[P_BOV]); // R9
    wire brakeWant = sleepOn && brakeReq; // R6
    wire brakeOn = brakeWant && !brakeOc_q && !dg[3]; // R8
    wire [7:0] brakeMask = EIGHT_BR ? BRAKE_MASK8 : BRAKE_MASK4; // R7

    // Brake overcurrent holds low sides off until braking ends
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            brakeOc_q <= 1'b0;
        end else if (clkEn) begin
            brakeOc_q <= brakeWant && (brakeOc_q || dg[3]); // R8
        end
    end

    // Registered outputs
    logic pulldown_q;
    logic [7:0] lsBrake_q;
    logic faultN_q;
    logic pinOeN_q;
    logic cpEn_q;
    logic monEn_q;
    logic bmonEn_q;
    logic [1:0] ovLvl_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pulldown_q <= 1'b1;
            lsBrake_q <= '0;
            faultN_q <= 1'b1;
            pinOeN_q <= 1'b1;
            cpEn_q <= 1'b0;
            monEn_q <= 1'b0;
            bmonEn_q <= 1'b0;
            ovLvl_q <= '0;
        end else if (clkEn) begin
            pulldown_q <= pulldownD;
            lsBrake_q <= brakeOn ? brakeMask : 8'h00;
            faultN_q <= !faultNow; // R24
            // Open drain: pull low only on fault in output mode
            pinOeN_q <= !(pinSel && faultNow); // R4
            cpEn_q <= !inactive_q && !uvFault_q; // R14 R15
            monEn_q <= !inactive_q; // R12
            bmonEn_q <= brakeOpen; // R9
            ovLvl_q <= cfg_q[CFG_OVLVL +: 2];
        end
    end

    // Status word for reads
    wire [DW-1:0] statWord = {1'b0, inactive_q, brakeOn,
        ovFlag_q, uvFlag_q, por_q, warn_q, faultNow};
    wire [DW-1:0] ctrlWord = {ctrl_q[DW-1:CTRL_CLR+1], clr_q,
        enBit};
    wire [DW-1:0] rdMux = (regAddr == ADDR_CTRL) ? ctrlWord
        : (regAddr == ADDR_CFG) ? cfg_q
        : (regAddr == ADDR_STAT) ? statWord : 8'h00;

    // Read data appears the cycle after the strobe only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdData_q <= '0;
        end else if (clkEn) begin
            rdData_q <= regRd ? rdMux : 8'h00;
        end
    end

    assign regRdData = rdData_q;
    assign disableOrIrqPinOut = 1'b0;
    assign disableOrIrqPinOeN = pinOeN_q;
    assign faultOutN = faultN_q;
    assign supplyHighThresholdSelect = ovLvl_q;
    assign brakeMonitorEn = bmonEn_q;
    assign monitorsEn = monEn_q;
    assign chargePumpEn = cpEn_q;
    assign gatePulldownEn = pulldown_q;
    assign lowSideBrake = lsBrake_q;

    // Checks on the protection paths
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    enable_low_a: assert property (clkEn && !enBit |=> gatePulldownEn) // R1
        else $error("drivers not held off with enable low");
    reset_en_a: assert property (disable iff (1'b0)
        rst |=> !ctrl_q[CTRL_EN] && gatePulldownEn) // R2
        else $error("enable bit not cleared by reset");
    pin_disable_a: assert property (clkEn && pinDisable |=> gatePulldownEn) // R5
        else $error("disable pin ignored");
    irq_pin_a: assert property (clkEn && pinSel && faultNow |=> !disableOrIrqPinOeN) // R4
        else $error("fault not driven on multi pin");
    brake_gate_a: assert property ($past(clkEn) && lowSideBrake != 8'h00 |-> lowSideBrake == brakeMask
        && $past(sleepOn) && $past(brakeReq)) // R6 R7
        else $error("braking outside sleep or wrong bridges");
    brake_oc_a: assert property (clkEn && dg[3] |=> lowSideBrake == 8'h00) // R8
        else $error("brake overcurrent did not stop low sides");
    clear_self_a: assert property (clkEn && clr_q && !wrCtrl |=> !clr_q) // R10
        else $error("clear bit did not drop");
    uv_hold_a: assert property (clkEn && uvFault_q && !uvAuto && !clrEff |=> uvFault_q) // R15
        else $error("latched supply low fault lost");
    uv_auto_a: assert property (clkEn && uvAuto && !uvDg |=> !uvFault_q) // R16
        else $error("auto supply low fault did not recover");
    uv_pin_a: assert property (clkEn && uvDg ##1 clkEn |=> !faultOutN && !chargePumpEn) // R14
        else $error("supply low did not raise fault");
    ov_warn_a: assert property (clkEn && ovMode == OVM_WARN && !ovFault_q |=> !ovFault_q) // R21
        else $error("warning mode acted on drivers");
    ov_off_a: assert property (clkEn && ovMode == OVM_OFF && !ovFlag_q |=> !ovFlag_q) // R22
        else $error("disabled monitor reported");
    por_hold_a: assert property (clkEn && por_q && !clrEff |=> por_q) // R13
        else $error("reset flag dropped without clear");

    brake_run_c: cover property (lowSideBrake != 8'h00);
    ov_warn_c: cover property (warn_q && !faultNow);
    uv_recover_c: cover property (uvFault_q ##1 !uvFault_q && uvFlag_q);
    clear_c: cover property (clr_q && por_q);
endmodule

// [src/gdfm_pkg.sv]
// Constants and encodings for the gate driver fault manager
// Behaviour
// R1: Disable pin or enable low forces pulldowns
// R2: Enable bit resets low; host sets it
// R3: Hardware variant enables drivers after power up
// R4: Multi pin: disable input or fault output
// R5: Pin high disables drivers, low runs
// R6: Braking only in sleep with brake high
// R7: Brake bridges 5-8 or all four together
// R8: Brake overcurrent turns low sides off
// R9: Open brake pin uses supply monitor
// R10: Fault clear bit clears faults, self-resets
// R11: Hardware variant recovers faults automatically
// R12: Logic undervoltage or sleep makes inactive
// R13: Power-on-reset flag holds until clear
// R14: Supply low fault: pulldowns, pump off
// R15: Latched low mode holds until clear
// R16: Auto low mode recovers, flag stays
// R17: Hardware variant uses auto low recovery
// R18: Supply high detected after programmable deglitch
// R19: Latched high mode holds until clear
// R20: Auto high mode recovers, flag stays
// R21: Warning mode only sets warn flag (code also sets the supply high flag)
// R22: Disabled high mode neither acts nor reports
// R23: Two-bit high mode, one-bit low mode
// R24: Fault output is OR of faults
package gdfm_pkg;
    // Clock rate and deglitch times
    localparam int CLK_MHZ = 200;
    localparam int CNT_W = 11;
    localparam int POR_DG_NS = 5000;
    localparam int UV_DG_NS = 10000;
    localparam int BOC_DG_NS = 1000;
    localparam int OV_DG0_NS = 1000;
    localparam int OV_DG1_NS = 2000;
    localparam int OV_DG2_NS = 4000;
    localparam int OV_DG3_NS = 8000;
    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] POR_DG_CYC = CNT_W'((POR_DG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] UV_DG_CYC = CNT_W'((UV_DG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] BOC_DG_CYC = CNT_W'((BOC_DG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] OV_DG0_CYC = CNT_W'((OV_DG0_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] OV_DG1_CYC = CNT_W'((OV_DG1_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] OV_DG2_CYC = CNT_W'((OV_DG2_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] OV_DG3_CYC = CNT_W'((OV_DG3_NS * CLK_MHZ + 999) / 1000);
    // Register bus
    localparam int AW = 8;
    localparam int DW = 8;
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_CFG = 8'h01;
    localparam logic [AW-1:0] ADDR_STAT = 8'h02;
    localparam logic [DW-1:0] CTRL_RST = 8'h00;
    localparam logic [DW-1:0] CFG_RST = 8'h00;
    // Control fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_CLR = 1;
    localparam int CTRL_PINSEL = 2;
    // Config fields
    localparam int CFG_UVMODE = 0;
    localparam int CFG_OVMODE = 1;
    localparam int CFG_OVLVL = 3;
    localparam int CFG_OVDG = 5;
    // Status fields
    localparam int ST_FAULT = 0;
    localparam int ST_WARN = 1;
    localparam int ST_POR = 2;
    localparam int ST_UV = 3;
    localparam int ST_OV = 4;
    localparam int ST_BRAKE = 5;
    localparam int ST_INACT = 6;
    // Supply high and supply low response codes
    localparam logic [1:0] OVM_LATCH = 2'h0;
    localparam logic [1:0] OVM_AUTO = 2'h1;
    localparam logic [1:0] OVM_WARN = 2'h2;
    localparam logic [1:0] OVM_OFF = 2'h3;
    localparam logic UVM_AUTO = 1'h1;
    // Braking low-side masks
    localparam logic [7:0] BRAKE_MASK8 = 8'hf0;
    localparam logic [7:0] BRAKE_MASK4 = 8'h0f;
    // Synchronised pin indices
    localparam int PIN_N = 8;
    localparam int P_SLEEPN = 0;
    localparam int P_MULTI = 1;
    localparam int P_BRAKE = 2;
    localparam int P_BOPEN = 3;
    localparam int P_BOV = 4;
    localparam int P_LLOW = 5;
    localparam int P_UV = 6;
    localparam int P_OV = 7;
endpackage

// [bench/gdfm_host_model.sv]
// Host model: register port master and control pins
`timescale 1ns/1ps
module gdfm_host_model (
    // Clock and read data
    input wire logic ref_clk,
    input wire logic [gdfm_pkg::DW-1:0] regRdData,
    // Register port
    output logic [gdfm_pkg::AW-1:0] regAddr,
    output logic [gdfm_pkg::DW-1:0] regWrData,
    output logic regWr,
    output logic regRd,
    // Control pins, pinLevel high also releases the open-drain line
    output logic sleepRequestN,
    output logic pinLevel,
    output logic brakePin
);
    import gdfm_pkg::*;
    // Idle bus and awake, running pins
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        sleepRequestN = 1'b1;
        pinLevel = 1'b0;
        brakePin = 1'b0;
    end
    // One-cycle write; data inverted after so stale values never match
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        regWrData <= ~d;
    endtask
    // One-cycle read, data taken in the following cycle only
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask
    // Pin levels: high on the multi pin disables drivers
    task automatic pins(input logic s, input logic p, input logic b);
        @(posedge ref_clk);
        sleepRequestN <= s;
        pinLevel <= p;
        brakePin <= b;
    endtask
endmodule

// [bench/gate_driver_fault_manager_bench.sv]
// Self-checking bench for the gate driver fault manager
`timescale 1ns/1ps
module gate_driver_fault_manager_bench;
    import gdfm_pkg::*;
    logic ref_clk, rst, clkEn, brakePinOpen, brakeSupplyHighCmp, brakeOverCurrentCmp;
    logic logicSupplyLowCmp, supplyLowCmp, supplyHighCmp, regWr, regRd;
    logic sleepRequestN, pinLevel, brakePin, pinWire, disableOrIrqPinOut, disableOrIrqPinOeN;
    logic faultOutN, brakeMonitorEn, monitorsEn, chargePumpEn, gatePulldownEn;
    logic [AW-1:0] regAddr;
    logic [DW-1:0] regWrData, regRdData, rdv, ctrlBase;
    logic [1:0] supplyHighThresholdSelect;
    logic [7:0] lowSideBrake, hwBrake;
    logic hwFaultN, hwPulldown;
    logic [31:0] seed = 32'h0000003c;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    bit f, w, o, fa;
    // Open-drain multi pin with pull-up
    assign pinWire = pinLevel & (disableOrIrqPinOeN | disableOrIrqPinOut);
    gdfm_fault_manager #(.HW_CFG(1'b0), .EIGHT_BR(1'b1)) dut (
        .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sleepRequestN(sleepRequestN),
        .disableOrIrqPinIn(pinWire), .disableOrIrqPinOut(disableOrIrqPinOut),
        .disableOrIrqPinOeN(disableOrIrqPinOeN), .faultOutN(faultOutN), .brakePin(brakePin),
        .brakePinOpen(brakePinOpen), .brakeSupplyHighCmp(brakeSupplyHighCmp),
        .brakeOverCurrentCmp(brakeOverCurrentCmp), .logicSupplyLowCmp(logicSupplyLowCmp),
        .supplyLowCmp(supplyLowCmp), .supplyHighCmp(supplyHighCmp),
        .supplyHighThresholdSelect(supplyHighThresholdSelect), .brakeMonitorEn(brakeMonitorEn),
        .monitorsEn(monitorsEn), .chargePumpEn(chargePumpEn), .gatePulldownEn(gatePulldownEn),
        .lowSideBrake(lowSideBrake));
    // Pin-configured variant with four bridges, fed the same stimulus
    gdfm_fault_manager #(.HW_CFG(1'b1), .EIGHT_BR(1'b0)) hw (
        .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(), .sleepRequestN(sleepRequestN),
        .disableOrIrqPinIn(pinWire), .disableOrIrqPinOut(), .disableOrIrqPinOeN(), .faultOutN(hwFaultN),
        .brakePin(brakePin), .brakePinOpen(brakePinOpen), .brakeSupplyHighCmp(brakeSupplyHighCmp),
        .brakeOverCurrentCmp(brakeOverCurrentCmp), .logicSupplyLowCmp(logicSupplyLowCmp),
        .supplyLowCmp(supplyLowCmp), .supplyHighCmp(supplyHighCmp), .supplyHighThresholdSelect(),
        .brakeMonitorEn(), .monitorsEn(), .chargePumpEn(), .gatePulldownEn(hwPulldown),
        .lowSideBrake(hwBrake));
    gdfm_host_model host (
        .ref_clk(ref_clk), .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .sleepRequestN(sleepRequestN), .pinLevel(pinLevel),
        .brakePin(brakePin));
    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Expected status byte
    function automatic logic [7:0] stv(input bit fl, input bit wn, input bit p, input bit u, input bit ov);
        logic [7:0] v;
        v = 8'h00;
        v[ST_FAULT] = fl;
        v[ST_WARN] = wn;
        v[ST_POR] = p;
        v[ST_UV] = u;
        v[ST_OV] = ov;
        return v;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
        host.rd(a, rdv);
        chk(rdv, e);
    endtask
    // Let registered outputs land before looking
    task automatic st(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic clr();
        host.wr(ADDR_CTRL, ctrlBase | 8'h02);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, far above the expected run length
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        brakePinOpen = 1'b0;
        brakeSupplyHighCmp = 1'b0;
        brakeOverCurrentCmp = 1'b0;
        logicSupplyLowCmp = 1'b0;
        supplyLowCmp = 1'b0;
        supplyHighCmp = 1'b0;
        ctrlBase = 8'h01;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        st(6);
        chk(8'(gatePulldownEn), 8'h01);
        chk(8'(hwPulldown), 8'h00);
        rdc(ADDR_CTRL, CTRL_RST);
        rdc(ADDR_CFG, CFG_RST);
        rdc(ADDR_STAT, stv(0, 0, 1, 0, 0));
        rdc(8'h07, 8'h00);
        // Random plain bits, drivers still disabled
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            host.wr(ADDR_CTRL, {seed[7:3], 3'b000});
            rdc(ADDR_CTRL, {seed[7:3], 3'b000});
            host.wr(ADDR_CFG, seed[15:8]);
            rdc(ADDR_CFG, seed[15:8]);
            chk(8'(supplyHighThresholdSelect), 8'(seed[12:11]));
        end
        host.wr(ADDR_STAT, 8'hff);
        rdc(ADDR_STAT, stv(0, 0, 1, 0, 0));
        $display("test registers done");
        host.wr(ADDR_CTRL, 8'h03);
        rdc(ADDR_CTRL, 8'h01);
        rdc(ADDR_STAT, 8'h00);
        chk(8'(gatePulldownEn), 8'h00);
        host.pins(1'b1, 1'b1, 1'b0);
        st(6);
        chk(8'(gatePulldownEn), 8'h01);
        host.pins(1'b1, 1'b0, 1'b0);
        st(6);
        chk(8'(gatePulldownEn), 8'h00);
        host.wr(ADDR_CTRL, 8'h00);
        st(3);
        chk(8'(gatePulldownEn), 8'h01);
        host.wr(ADDR_CTRL, ctrlBase);
        $display("test disable done");
        // Supply low, latched then automatic
        for (int u = 0; u < 2; u++) begin
            host.wr(ADDR_CFG, {5'h00, OVM_OFF, u[0]});
            @(posedge ref_clk);
            supplyLowCmp <= 1'b1;
            st(2010);
            chk({5'h00, faultOutN, chargePumpEn, gatePulldownEn}, 8'h01);
            chk(8'(hwFaultN), 8'h00);
            rdc(ADDR_STAT, stv(1, 0, 0, 1, 0));
            @(posedge ref_clk);
            supplyLowCmp <= 1'b0;
            st(6);
            chk({5'h00, faultOutN, chargePumpEn, gatePulldownEn}, u[0] ? 8'h06 : 8'h01);
            chk(8'(hwFaultN), 8'h01);
            rdc(ADDR_STAT, stv(!u[0], 0, 0, 1, 0));
            clr();
            st(4);
            chk({5'h00, faultOutN, chargePumpEn, gatePulldownEn}, 8'h06);
            rdc(ADDR_STAT, 8'h00);
        end
        $display("test supply low done");
        // Supply high in every response mode, pin as fault output
        ctrlBase = 8'h05;
        host.wr(ADDR_CTRL, ctrlBase);
        host.pins(1'b1, 1'b1, 1'b0);
        for (int m = 0; m < 4; m++) begin
            f = (m < 2);
            w = (m == 2);
            o = (m != 3);
            fa = (m == 0);
            host.wr(ADDR_CFG, {5'h00, m[1:0], 1'b1});
            @(posedge ref_clk);
            supplyHighCmp <= 1'b1;
            st(150);
            chk(8'(faultOutN), 8'h01);
            st(60);
            chk({5'h00, faultOutN, gatePulldownEn, pinWire}, {5'h00, !f, f, !f});
            chk(8'(hwFaultN), 8'h01);
            rdc(ADDR_STAT, stv(f, w, 0, 0, o));
            @(posedge ref_clk);
            supplyHighCmp <= 1'b0;
            st(6);
            chk({6'h00, faultOutN, gatePulldownEn}, {6'h00, !fa, fa});
            rdc(ADDR_STAT, stv(fa, w, 0, 0, o));
            clr();
            rdc(ADDR_STAT, 8'h00);
        end
        ctrlBase = 8'h01;
        host.wr(ADDR_CTRL, ctrlBase);
        host.pins(1'b1, 1'b0, 1'b0);
        $display("test supply high done");
        @(posedge ref_clk);
        logicSupplyLowCmp <= 1'b1;
        st(1010);
        chk({5'h00, monitorsEn, chargePumpEn, gatePulldownEn}, 8'h01);
        @(posedge ref_clk);
        logicSupplyLowCmp <= 1'b0;
        st(6);
        chk({6'h00, monitorsEn, chargePumpEn}, 8'h03);
        rdc(ADDR_STAT, stv(0, 0, 1, 0, 0));
        clr();
        rdc(ADDR_STAT, 8'h00);
        $display("test logic supply done");
        // Sleep and powered-off braking
        host.pins(1'b0, 1'b0, 1'b0);
        st(6);
        chk({5'h00, monitorsEn, chargePumpEn, gatePulldownEn}, 8'h01);
        chk(lowSideBrake, 8'h00);
        host.pins(1'b0, 1'b0, 1'b1);
        st(6);
        chk(lowSideBrake, BRAKE_MASK8);
        chk(hwBrake, BRAKE_MASK4);
        @(posedge ref_clk);
        brakeOverCurrentCmp <= 1'b1;
        st(210);
        chk(lowSideBrake, 8'h00);
        @(posedge ref_clk);
        brakeOverCurrentCmp <= 1'b0;
        host.pins(1'b1, 1'b0, 1'b1);
        st(6);
        chk(lowSideBrake, 8'h00);
        chk({6'h00, monitorsEn, chargePumpEn}, 8'h03);
        host.pins(1'b0, 1'b0, 1'b0);
        brakePinOpen <= 1'b1;
        brakeSupplyHighCmp <= 1'b1;
        st(6);
        chk({lowSideBrake[7:1], brakeMonitorEn}, {BRAKE_MASK8[7:1], 1'b1});
        @(posedge ref_clk);
        brakePinOpen <= 1'b0;
        st(6);
        chk(lowSideBrake, 8'h00);
        host.pins(1'b1, 1'b0, 1'b0);
        $display("test braking done");
        stop_test();
    end
endmodule
